// *** verilog/serial_rx_pkg.sv ***
// Register map, field positions, reset values and carriers of the slave receiver.
// Assumes byte-wide registers reached over a plain strobe port.
package serial_rx_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned REG_ADDR_W    = 3;
  localparam logic [2:0]  OFS_RX_STATUS = 3'h0;
  localparam logic [2:0]  OFS_RX_DATA   = 3'h1;
  localparam logic [2:0]  OFS_TX_STATUS = 3'h2;
  localparam logic [2:0]  OFS_BAUD_CTL  = 3'h3;
  localparam logic [2:0]  OFS_DIV_HIGH  = 3'h4;
  localparam logic [2:0]  OFS_DIV_LOW   = 3'h5;
  localparam logic [2:0]  OFS_INT_CTL   = 3'h6;

  // ==========================================================================
  // Field positions
  localparam int unsigned RSC_PORT_EN   = 7;
  localparam int unsigned RSC_NINE_EN   = 6;
  localparam int unsigned RSC_SINGLE_EN = 5;
  localparam int unsigned RSC_CONT_EN   = 4;
  localparam int unsigned RSC_ADDR_DET  = 3;
  localparam int unsigned RSC_FRAME_ERR = 2;
  localparam int unsigned RSC_OVERRUN   = 1;
  localparam int unsigned RSC_NINTH     = 0;
  localparam int unsigned TSC_CLK_SRC   = 7;
  localparam int unsigned TSC_SYNC      = 4;
  localparam int unsigned INT_RX_ENABLE = 0;
  localparam int unsigned INT_RX_FLAG   = 1;

  // ==========================================================================
  // Reset values and sizes
  localparam logic [7:0]  RX_STATUS_RESET = 8'h00;
  localparam logic [7:0]  TX_STATUS_RESET = 8'h00;
  localparam logic [7:0]  BAUD_CTL_RESET  = 8'h00;
  localparam logic [7:0]  DIV_RESET       = 8'h00;
  localparam int unsigned DATA_BITS       = 8;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_t;

  typedef struct packed {
    logic                 ninth;
    logic [DATA_BITS-1:0] data;
  } rx_word_t;

  typedef struct packed {
    logic port_en;
    logic nine_en;
    logic single_en;
    logic cont_en;
    logic addr_det;
  } rx_ctl_t;

  typedef struct packed {
    rx_ctl_t    ctl;
    logic [7:0] tsc;
    logic [7:0] baud_ctl;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic       rie;
    logic       rif;
    logic       overrun_error_flag;
    rx_word_t   data;
    logic       link_en;
    logic       tog_last;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
  } rx_state_t;

endpackage

// *** verilog/bit_sync.sv ***
// Two-flop synchroniser for level signals into the domain of clk.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/10ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  input  logic         clk,
  input  logic         rst,
  input  logic         ce,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  if (W < 1) begin : g_chk
    $error("bit_sync needs W of at least one");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stab;

endmodule

// *** verilog/rx_shifter.sv ***
// Shift-clock side of the slave receiver: assembles words from the data pin.
// Assumes enable and nine_en are already synchronised to shift_clk.
`timescale 1ns/10ps
module rx_shifter
  import serial_rx_pkg::*;
#(
  parameter int unsigned DATA_BITS_P = DATA_BITS
) (
  input  logic     shift_clk,
  input  logic     rst,
  input  logic     enable,
  input  logic     nine_en,
  input  logic     data_in,
  output rx_word_t word,
  output logic     word_tog
);

  if (DATA_BITS_P != DATA_BITS) begin : g_chk
    $error("rx_shifter supports only the byte-wide word");
  end

  typedef struct packed {
    logic [DATA_BITS_P:0] sh;
    logic [3:0]           cnt;
    rx_word_t             hold;
    logic                 tog;
  } link_state_t;

  link_state_t s_q;
  link_state_t s_d;
  logic [3:0]  last;

  // ==========================================================================
  // Bit assembly, least significant bit first
  always_comb begin
    s_d  = s_q;
    last = nine_en ? 4'(DATA_BITS_P) : 4'(DATA_BITS_P - 1);
    if (!enable) begin
      s_d.cnt = '0;
    end else begin
      s_d.sh[s_q.cnt] = data_in;
      if (s_q.cnt >= last) begin
        // Hold stays stable for a whole word, so the far side can sample it
        s_d.cnt        = '0;
        s_d.hold.data  = s_d.sh[DATA_BITS_P-1:0];                     // [R3]
        s_d.hold.ninth = nine_en & s_d.sh[DATA_BITS_P];               // [R6]
        s_d.tog        = ~s_q.tog;
      end else begin
        s_d.cnt = 4'(s_q.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign word     = s_q.hold;
  assign word_tog = s_q.tog;

  AST_WORD_DONE: assert property (@(posedge shift_clk) disable iff (rst) // [R3]
    enable && s_q.cnt == last |=> word_tog != $past(word_tog) && s_q.cnt == 4'h0)
    else $error("completed word did not toggle");

  AST_NINE_LEN: assert property (@(posedge shift_clk) disable iff (rst) // [R6]
    enable && !nine_en && s_q.cnt == 4'h7 ##1 enable |-> s_q.cnt == 4'h0)
    else $error("eight-bit word length wrong");

endmodule

// *** verilog/sync_slave_serial_receiver.sv ***
// Synchronous slave receiver: register file, word hand-over and flags.
// Assumes an external master drives the shift clock and data pins, and a
// same-clock software port with one-cycle strobes.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// Functional notes
// (R1) Slave ignores single-word receive enable
// (R2) Words still received in low-power states
// (R3) Completed word moves into data register
// (R4) Enabled receive interrupt wakes the chip
// (R5) Software selects sync, port enable, slave
// (R6) Nine-bit enable adds a ninth bit
// (R7) No reception without continuous receive enable
// (R8) Flag set per word; interrupt when enabled
// (R9) Status shows ninth bit and errors
// (R10) Data read returns oldest word's bits
// (R11) Clearing continuous receive clears errors
// (R12) Clock source select zero means slave
// (R13) Master supplies shift clock on pin
// (R14) Unread word plus new word sets overrun
module sync_slave_serial_receiver
  import serial_rx_pkg::*;
(
  input  logic       clk,
  input  logic       rst,
  input  logic       ce,
  input  reg_req_t   req,
  output logic [7:0] rdata,
  input  logic       shift_clock_pin,
  input  logic       serial_data_pin,
  input  logic       low_power,
  output logic       rx_irq,
  output logic       wake_req
);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] status_byte(rx_ctl_t c, logic ovr, logic ninth);
    logic [7:0] b;
    b                = '0;
    b[RSC_PORT_EN]   = c.port_en;
    b[RSC_NINE_EN]   = c.nine_en;
    b[RSC_SINGLE_EN] = c.single_en;
    b[RSC_CONT_EN]   = c.cont_en;
    b[RSC_ADDR_DET]  = c.addr_det;
    // No stop bit in synchronous mode, so framing never fails
    b[RSC_FRAME_ERR] = 1'b0;
    b[RSC_OVERRUN]   = ovr;
    b[RSC_NINTH]     = ninth & c.nine_en;
    return b;
  endfunction

  function automatic rx_ctl_t ctl_from_byte(logic [7:0] b);
    rx_ctl_t c;
    c.port_en   = b[RSC_PORT_EN];
    c.nine_en   = b[RSC_NINE_EN];
    c.single_en = b[RSC_SINGLE_EN];
    c.cont_en   = b[RSC_CONT_EN];
    c.addr_det  = b[RSC_ADDR_DET];
    return c;
  endfunction

  // ==========================================================================
  // Shift-clock domain
  rx_state_t  s_q;
  rx_state_t  s_d;
  logic [1:0] cfg_link;
  rx_word_t   word_bus;
  logic       word_tog;
  logic       tog_s;

  // Shift clock comes only from the master pin; none is generated here [R13]
  bit_sync #(
    .W (2)
  ) u_cfg_sync (
    .clk (shift_clock_pin),
    .rst (rst),
    .ce  (1'b1),
    .d   ({s_q.link_en, s_q.ctl.nine_en}),
    .q   (cfg_link)
  );

  rx_shifter #(
    .DATA_BITS_P (DATA_BITS)
  ) u_shifter (
    .shift_clk (shift_clock_pin),
    .rst       (rst),
    .enable    (cfg_link[1]),
    .nine_en   (cfg_link[0]),
    .data_in   (serial_data_pin),
    .word      (word_bus),
    .word_tog  (word_tog)
  );

  // ==========================================================================
  // Word hand-over into clk
  // Toggle crossing; the held word is stable for a full word time after it
  bit_sync #(
    .W (1)
  ) u_tog_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (word_tog),
    .q   (tog_s)
  );

  logic done;
  logic wr_status;
  logic rd_data;

  assign done      = tog_s ^ s_q.tog_last;
  assign wr_status = req.wr && req.addr == OFS_RX_STATUS;
  assign rd_data   = req.rd && req.addr == OFS_RX_DATA;

  // ==========================================================================
  // Register file and flags
  always_comb begin
    s_d          = s_q;
    s_d.rdata    = '0;
    s_d.tog_last = tog_s;

    if (req.wr) begin
      unique case (req.addr)
        OFS_RX_STATUS: begin
          s_d.ctl = ctl_from_byte(req.wdata);
          if (!req.wdata[RSC_CONT_EN]) begin
            s_d.overrun_error_flag = 1'b0;                                          // [R11]
          end
        end
        OFS_TX_STATUS: s_d.tsc      = req.wdata;
        OFS_BAUD_CTL:  s_d.baud_ctl = req.wdata;
        OFS_DIV_HIGH:  s_d.div_hi   = req.wdata;
        OFS_DIV_LOW:   s_d.div_lo   = req.wdata;
        OFS_INT_CTL:   s_d.rie      = req.wdata[INT_RX_ENABLE];
        default: ;
      endcase
    end

    if (req.rd) begin
      unique case (req.addr)
        OFS_RX_STATUS: s_d.rdata = status_byte(s_q.ctl, s_q.overrun_error_flag, s_q.data.ninth); // [R9]
        OFS_RX_DATA: begin
          s_d.rdata = s_q.data.data;                                  // [R10]
          s_d.rif   = 1'b0;
        end
        OFS_TX_STATUS: s_d.rdata = s_q.tsc;
        OFS_BAUD_CTL:  s_d.rdata = s_q.baud_ctl;
        OFS_DIV_HIGH:  s_d.rdata = s_q.div_hi;
        OFS_DIV_LOW:   s_d.rdata = s_q.div_lo;
        OFS_INT_CTL: begin
          s_d.rdata[INT_RX_ENABLE] = s_q.rie;
          s_d.rdata[INT_RX_FLAG]   = s_q.rif;
        end
        default: ;
      endcase
    end

    // Word arrival after clears, so a set wins over a same-cycle clear
    if (done) begin
      if (s_q.rif && !rd_data) begin
        // Unread word is kept; the new one is dropped
        s_d.overrun_error_flag = 1'b1;                                              // [R14]
      end else begin
        s_d.data = word_bus;                                          // [R3]
        s_d.rif  = 1'b1;                                              // [R8]
      end
    end

    // Single-word enable plays no part in slave mode [R1]
    s_d.link_en = s_d.ctl.port_en && s_d.tsc[TSC_SYNC]                // [R5]
                  && !s_d.tsc[TSC_CLK_SRC]                            // [R12]
                  && s_d.ctl.cont_en                                  // [R7]
                  && !s_d.overrun_error_flag;
    s_d.irq  = s_d.rie && s_d.rif;                                    // [R8]
    // Reception keeps running in low power; only the wake depends on it [R2]
    s_d.wake = low_power && s_d.rie && s_d.rif;                       // [R4]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.ctl      <= rx_ctl_t'(RX_STATUS_RESET[RSC_PORT_EN:RSC_ADDR_DET]);
      s_q.tsc      <= TX_STATUS_RESET;
      s_q.baud_ctl <= BAUD_CTL_RESET;
      s_q.div_hi   <= DIV_RESET;
      s_q.div_lo   <= DIV_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata    = s_q.rdata;
  assign rx_irq   = s_q.irq;
  assign wake_req = s_q.wake;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_READ_DATA: assert property ( // [R10]
    ce && rd_data |=> rdata == $past(s_q.data.data))
    else $error("data read returned wrong byte");

  AST_READ_STATUS: assert property ( // [R9]
    ce && req.rd && req.addr == OFS_RX_STATUS
    |=> rdata[RSC_OVERRUN] == $past(s_q.overrun_error_flag)
        && rdata[RSC_NINTH] == ($past(s_q.data.ninth) && $past(s_q.ctl.nine_en)))
    else $error("status read shows wrong error or ninth bit");

  AST_WORD_STORED: assert property ( // [R3]
    ce && done && !s_q.rif |=> s_q.rif && s_q.data == $past(word_bus))
    else $error("completed word not moved to data register");

  AST_OVERRUN: assert property ( // [R14]
    ce && done && s_q.rif && !rd_data |=> s_q.overrun_error_flag && $stable(s_q.data))
    else $error("overrun not flagged or data overwritten");

  AST_OVERRUN_HOLD: assert property ( // [R14]
    ce && s_q.overrun_error_flag && !wr_status |=> s_q.overrun_error_flag)
    else $error("overrun dropped without clearing receive enable");

  AST_CLEAR_ERR: assert property ( // [R11]
    ce && wr_status && !req.wdata[RSC_CONT_EN] && !done |=> !s_q.overrun_error_flag)
    else $error("clearing receive enable kept the error");

  AST_NEEDS_ENABLE: assert property ( // [R7]
    s_q.link_en |-> s_q.ctl.cont_en && s_q.ctl.port_en && s_q.tsc[TSC_SYNC])
    else $error("link enabled without continuous receive");

  AST_SLAVE_ONLY: assert property ( // [R12]
    ce && req.wr && req.addr == OFS_TX_STATUS && req.wdata[TSC_CLK_SRC]
    |=> !s_q.link_en)
    else $error("receiver enabled with internal clock source");

  AST_SINGLE_IGNORED: assert property ( // [R1]
    ce && !s_q.overrun_error_flag && s_q.ctl.port_en && s_q.tsc[TSC_SYNC] && !s_q.tsc[TSC_CLK_SRC]
    && s_q.ctl.cont_en && !req.wr && !done |=> s_q.link_en)
    else $error("single-word enable affected slave reception");

  AST_IRQ_GATE: assert property ( // [R8]
    ce && done && !s_q.rif && !req.wr |=> rx_irq == $past(s_q.rie))
    else $error("receive interrupt not gated by its enable");

  AST_WAKE: assert property ( // [R4]
    ce && done && !s_q.rif && s_q.rie && low_power && !req.wr |=> wake_req)
    else $error("completed word did not wake the chip");

  AST_LOW_POWER_RX: assert property ( // [R2]
    ce && low_power && done && !s_q.rif |=> s_q.rif)
    else $error("word lost while in low power");

  // ==========================================================================
  // Flag, data, hand-over, enable, interrupt, wake and read-back checks

  AST_RDATA_IDLE: assert property ( // [R10]
    ce && !req.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  AST_WAKE_NEEDS_LP: assert property ( // [R4]
    ce && !low_power |=> !wake_req)
    else $error("wake raised outside low power");

  AST_FLAG_CLEAR: assert property ( // [R8]
    ce && rd_data && !done |=> !s_q.rif)
    else $error("data read did not clear the receive flag");

  AST_FLAG_HOLD: assert property ( // [R8]
    ce && s_q.rif && !rd_data |=> s_q.rif)
    else $error("receive flag dropped without a data read");

  AST_DATA_HOLD: assert property ( // [R10]
    ce && !done |=> $stable(s_q.data))
    else $error("data register changed without a word");

  AST_NO_FRAME_ERR: assert property ( // [R9]
    ce && req.rd && req.addr == OFS_RX_STATUS |=> !rdata[RSC_FRAME_ERR])
    else $error("framing error shown in synchronous mode");

  AST_OVERRUN_ERROR_FLAG_BLOCKS: assert property ( // [R14]
    s_q.overrun_error_flag |-> !s_q.link_en)
    else $error("link enabled while overrun latched");

  AST_CONT_WRITE: assert property ( // [R7]
    ce && wr_status |=> s_q.ctl.cont_en == $past(req.wdata[RSC_CONT_EN]))
    else $error("continuous receive enable not stored");

  AST_RIE_WRITE: assert property ( // [R8]
    ce && req.wr && req.addr == OFS_INT_CTL
    |=> s_q.rie == $past(req.wdata[INT_RX_ENABLE]))
    else $error("receive interrupt enable not stored");

  AST_NO_CONT: assert property ( // [R7]
    !s_q.ctl.cont_en |-> !s_q.link_en)
    else $error("link enabled without continuous receive");

  AST_CLOCK_SRC: assert property ( // [R12]
    s_q.tsc[TSC_CLK_SRC] |-> !s_q.link_en)
    else $error("link enabled with internal clock source");

  AST_WAKE_LEVEL: assert property ( // [R4]
    ce |=> wake_req == ($past(low_power) && s_q.rie && s_q.rif))
    else $error("wake request not low power with pending interrupt");

  AST_IRQ_LEVEL: assert property ( // [R8]
    ce |=> rx_irq == (s_q.rie && s_q.rif))
    else $error("interrupt not enable and flag");

  AST_DONE_PULSE: assert property ( // [R3]
    ce && done |=> !done)
    else $error("word hand-over seen twice");

  AST_READ_TSC: assert property ( // [R12]
    ce && req.rd && req.addr == OFS_TX_STATUS |=> rdata == $past(s_q.tsc))
    else $error("transmit status read back wrong");

  AST_SET_WINS: assert property ( // [R8]
    ce && done && rd_data |=> s_q.rif && s_q.data == $past(word_bus))
    else $error("word lost when completing during a data read");

  AST_OVERRUN_ERROR_FLAG_ONLY_DONE: assert property ( // [R14]
    ce && !s_q.overrun_error_flag && !done |=> !s_q.overrun_error_flag)
    else $error("overrun set without a word");

  AST_FLAG_ONLY_DONE: assert property ( // [R8]
    ce && !s_q.rif && !done |=> !s_q.rif)
    else $error("receive flag set without a word");

  AST_SINGLE_STORED: assert property ( // [R1]
    ce && wr_status |=> s_q.ctl.single_en == $past(req.wdata[RSC_SINGLE_EN]))
    else $error("single-word enable not stored");

  AST_READ_FLAG: assert property ( // [R8]
    ce && req.rd && req.addr == OFS_INT_CTL |=> rdata[INT_RX_FLAG] == $past(s_q.rif))
    else $error("interrupt register shows wrong flag");

  AST_READ_CONT: assert property ( // [R9]
    ce && req.rd && req.addr == OFS_RX_STATUS
    |=> rdata[RSC_CONT_EN] == $past(s_q.ctl.cont_en))
    else $error("status read shows wrong receive enable");

endmodule

// *** tb/sync_master_model.sv ***
// Far-side master model: drives the shift clock and serial data pins.
// Assumes the bench calls send; the clock stands low between frames.
`timescale 1ns/10ps
module sync_master_model (
  output logic sclk,
  output logic sdata
);
  initial begin
    sclk  = 1'b0;
    sdata = 1'b1;
  end

  // ==========================================================================
  // Frame driver
  // Warm-up edges let the receiver's enable cross before the first bit
  task automatic send(input logic [8:0] w, input int n, input int warm);
    #7;
    for (int i = -warm; i < n; i++) begin
      sdata = (i < 0) ? ~sdata : w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    // Released line shows the inverse, never a stale level
    sdata = ~sdata;
  endtask
endmodule

// *** tb/test_sync_slave_serial_receiver.sv ***
// Self-checking bench of the synchronous slave receiver.
// Assumes the far-side master model and a 50 MHz system clock.
`timescale 1ns/10ps
module test_sync_slave_serial_receiver;
  import serial_rx_pkg::*;
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  logic       ce        = 1'b1;
  logic       low_power = 1'b0;
  reg_req_t   req       = '0;
  logic [7:0] rdata;
  logic       sclk;
  logic       sdata;
  logic       rx_irq;
  logic       wake_req;
  logic [7:0] v;
  int         num_errors      = 0;
  int         samples_checked = 0;

  always #10 clk = ~clk;

  sync_slave_serial_receiver dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
    .shift_clock_pin(sclk), .serial_data_pin(sdata), .low_power(low_power),
    .rx_irq(rx_irq), .wake_req(wake_req));
  sync_master_model master (.sclk(sclk), .sdata(sdata));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] bit8(input logic b, input int unsigned p);
    return {7'h00, b} << p;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(name, rdata, exp);
  endtask
  // Shift clock stands still between frames, so clock the disable across
  // to drop a stale count before nine-bit and enable cross on warm-up edges
  task automatic cfg(input logic nine, input logic cont, input logic src, input logic rie);
    wr(OFS_RX_STATUS, 8'h00);
    master.send(9'h000, 0, 3);
    wr(OFS_TX_STATUS, bit8(src, TSC_CLK_SRC) | bit8(1'b1, TSC_SYNC));
    wr(OFS_INT_CTL, {7'h00, rie});
    wr(OFS_RX_STATUS, bit8(1'b1, RSC_PORT_EN) | bit8(nine, RSC_NINE_EN)
                      | bit8(cont, RSC_CONT_EN));
  endtask
  // Hand-over to the flag takes at most four clocks after the last bit
  task automatic xfer(input logic [8:0] w, input int n, input int warm);
    master.send(w, n, warm);
    repeat (6) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rchk("reset", 3'(a), 8'h00);
    end
  endtask
  task automatic t_regs();
    for (int a = 2; a < 6; a++) begin
      wr(3'(a), 8'h3C + 8'(a));
      rchk("rw", 3'(a), 8'h3C + 8'(a));
    end
    wr(OFS_RX_DATA, 8'h77);
    rchk("data ro", OFS_RX_DATA, 8'h00);
    wr(3'h7, 8'h77);
    rchk("unmapped", 3'h7, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_DIV_LOW, 8'h11);
    ce <= 1'b1;
    rchk("ce low", OFS_DIV_LOW, 8'h41);
    wr(OFS_INT_CTL, 8'h03);
    rchk("flag ro", OFS_INT_CTL, 8'h01);
    wr(OFS_RX_STATUS, 8'hFF);
    rchk("status ro", OFS_RX_STATUS, 8'hF8);
    wr(OFS_RX_STATUS, 8'h00);
  endtask
  task automatic t_disabled();
    cfg(1'b0, 1'b1, 1'b1, 1'b1);
    xfer(9'h096, 8, 2);
    rchk("master mode", OFS_INT_CTL, 8'h01);
    cfg(1'b0, 1'b0, 1'b0, 1'b1);
    xfer(9'h096, 8, 2);
    rchk("no cont", OFS_INT_CTL, 8'h01);
    check("irq off", {7'h00, rx_irq}, 8'h00);
  endtask
  task automatic t_basic();
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    wr(OFS_RX_STATUS, 8'hB0);
    xfer(9'h0A5, 8, 2);
    check("irq masked", {7'h00, rx_irq}, 8'h00);
    rchk("flag", OFS_INT_CTL, 8'h02);
    rchk("data", OFS_RX_DATA, 8'hA5);
    rchk("flag clr", OFS_INT_CTL, 8'h00);
    xfer(9'h0C3, 8, 0);
    rchk("single ignored", OFS_RX_DATA, 8'hC3);
    wr(OFS_INT_CTL, 8'h01);
    xfer(9'h03C, 8, 0);
    check("irq", {7'h00, rx_irq}, 8'h01);
    check("no wake", {7'h00, wake_req}, 8'h00);
    rchk("data 2", OFS_RX_DATA, 8'h3C);
    check("irq clr", {7'h00, rx_irq}, 8'h00);
  endtask
  task automatic t_nine();
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    xfer(9'h15A, 9, 2);
    rchk("ninth 1", OFS_RX_STATUS, 8'hD1);
    rchk("data 9", OFS_RX_DATA, 8'h5A);
    xfer(9'h0A3, 9, 0);
    rchk("ninth 0", OFS_RX_STATUS, 8'hD0);
    rchk("data 9b", OFS_RX_DATA, 8'hA3);
  endtask
  task automatic t_sleep();
    cfg(1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    low_power <= 1'b1;
    xfer(9'h081, 8, 2);
    check("wake", {7'h00, wake_req}, 8'h01);
    check("irq lp", {7'h00, rx_irq}, 8'h01);
    rchk("data lp", OFS_RX_DATA, 8'h81);
    check("wake clr", {7'h00, wake_req}, 8'h00);
    @(posedge clk);
    low_power <= 1'b0;
  endtask
  task automatic t_overrun();
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    xfer(9'h011, 8, 2);
    xfer(9'h022, 8, 0);
    rchk("overrun", OFS_RX_STATUS, 8'h92);
    rchk("oldest", OFS_RX_DATA, 8'h11);
    xfer(9'h033, 8, 0);
    rchk("blocked", OFS_INT_CTL, 8'h00);
    rchk("held", OFS_RX_STATUS, 8'h92);
    wr(OFS_RX_STATUS, 8'h80);
    rchk("err clr", OFS_RX_STATUS, 8'h80);
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    xfer(9'h044, 8, 2);
    rchk("resumed", OFS_RX_DATA, 8'h44);
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_disabled();
    t_basic();
    t_nine();
    t_sleep();
    t_overrun();
    final_report();
  end

  // Whole run needs about 9 us
  initial begin
    #50us;
    num_errors++;
    final_report();
  end
endmodule
